// file: hdl/hsie_irq_ctrl.v
// Per-slot event status and interrupt enable registers for four hot-plug
// slots, with a shared open-drain interrupt line, behind an APB slave.
// Assumes slot pins are asynchronous and the bus switch control comes from
// sequencing logic clocked by pclk.
`timescale 1ns/10ps
`default_nettype none
`include "hsie_defines.vh"

// Notes on behaviour
// - Enable bit 7 always reads zero; writes to it are dropped.
// - Enable bit 6 raises the interrupt when the bus switch goes low.
// - Enable bit 5 raises the interrupt on any power-ok level change.
// - Enable bit 4 raises the interrupt when power fault asserts.
// - Enable bit 3 raises the interrupt on mechanical sense B changes.
// - Enable bit 2 raises the interrupt on mechanical sense A changes.
// - Enable bit 1 raises the interrupt on card present B changes.
// - Enable bit 0 raises the interrupt on card present A changes.
// - Enable registers sit at 07h, 0Fh, 17h, 1Fh and reset to zero.
// - The interrupt is open-drain: pulled low when active, else released.
// - Every event is latched in status whether or not it is enabled.
// - Status bits stay set until software writes one; zero leaves them.
module hsie_irq_ctrl #(
  parameter NUM_SLOTS = 4,
  parameter FAULT_ACTIVE_HIGH = 1
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [NUM_SLOTS-1:0] bus_connect_switch_out,
  input wire [NUM_SLOTS-1:0] slot_power_ok_in,
  input wire [NUM_SLOTS-1:0] slot_power_fault_in,
  input wire [NUM_SLOTS-1:0] mech_sense_a_in,
  input wire [NUM_SLOTS-1:0] mech_sense_b_in,
  input wire [NUM_SLOTS-1:0] card_present_a_in,
  input wire [NUM_SLOTS-1:0] card_present_b_in,
  input wire hotplug_irq_in,
  output wire hotplug_irq_out,
  output wire hotplug_irq_oe
);

  localparam PINS = 6 * NUM_SLOTS + 1;
  localparam N = NUM_SLOTS;

  // Address decoding, used by the read path and the write path alike
  function is_word;
    input [7:0] addr;
    begin
      is_word = (addr[1:0] == 2'h0);
    end
  endfunction

  function [5:0] index_of;
    input [7:0] addr;
    begin
      index_of = addr[7:2];
    end
  endfunction

  // Slot registers repeat with a stride of eight words
  function is_slot_reg;
    input [5:0] idx;
    input is_enable;
    reg [5:0] low;
    begin
      low = idx & `HSIE_IDX_SLOT_MASK;
      if (idx > `HSIE_IDX_LAST_SLOT) begin
        is_slot_reg = 1'b0;
      end else if (is_enable) begin
        is_slot_reg = (low == (`HSIE_IDX_EN0 & `HSIE_IDX_SLOT_MASK));
      end else begin
        is_slot_reg = (low == (`HSIE_IDX_STAT0 & `HSIE_IDX_SLOT_MASK));
      end
    end
  endfunction

  function [1:0] slot_of;
    input [5:0] idx;
    begin
      slot_of = idx[4:3];
    end
  endfunction

  // Pin synchroniser outputs
  wire [PINS-1:0] pin_raw;
  wire [PINS-1:0] pin_lvl;
  wire [PINS-1:0] pin_rise;
  wire [PINS-1:0] pin_fall;
  wire pins_primed;

  assign pin_raw = {hotplug_irq_in,
                    card_present_b_in,
                    card_present_a_in,
                    mech_sense_b_in,
                    mech_sense_a_in,
                    slot_power_fault_in,
                    slot_power_ok_in};

  hsie_sync3 #(
    .WIDTH(PINS)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(pin_raw),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall),
    .primed(pins_primed)
  );

  wire [N-1:0] pwr_ok_chg;
  wire [N-1:0] fault_rise;
  wire [N-1:0] fault_fall;
  wire [N-1:0] mech_a_chg;
  wire [N-1:0] mech_b_chg;
  wire [N-1:0] card_a_chg;
  wire [N-1:0] card_b_chg;
  wire [N-1:0] fault_asserted;
  wire line_low;

  // Changes in either direction count for all these pins but power fault
  assign pwr_ok_chg = pin_rise[N-1:0] | pin_fall[N-1:0];
  assign fault_rise = pin_rise[2*N-1:N];
  assign fault_fall = pin_fall[2*N-1:N];
  assign mech_a_chg = pin_rise[3*N-1:2*N] | pin_fall[3*N-1:2*N];
  assign mech_b_chg = pin_rise[4*N-1:3*N] | pin_fall[4*N-1:3*N];
  assign card_a_chg = pin_rise[5*N-1:4*N] | pin_fall[5*N-1:4*N];
  assign card_b_chg = pin_rise[6*N-1:5*N] | pin_fall[6*N-1:5*N];
  // Fault polarity is a board choice; only the asserting edge counts
  assign fault_asserted = FAULT_ACTIVE_HIGH ? fault_rise : fault_fall;
  assign line_low = ~pin_lvl[PINS-1];

  // Bus switch control is on our clock, so only an edge detector is needed
  reg [N-1:0] bus_sw_prev_ff;
  wire [N-1:0] bus_sw_low;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_sw_prev_ff <= {N{1'b0}};
    end else begin
      bus_sw_prev_ff <= bus_connect_switch_out;
    end
  end

  // Starts low after reset, so a switch held low gives no false event
  assign bus_sw_low = bus_sw_prev_ff & ~bus_connect_switch_out;

  // APB decode
  wire [5:0] idx;
  wire [1:0] slot;
  wire hit_en;
  wire hit_stat;
  wire hit_line;
  wire hit_any;
  wire setup_ph;
  wire wr_take;
  wire lane0;

  assign idx = index_of(paddr);
  assign slot = slot_of(idx);
  assign hit_en = is_word(paddr) & is_slot_reg(idx, 1'b1) &
                  ({4'h0, slot} < N);
  assign hit_stat = is_word(paddr) & is_slot_reg(idx, 1'b0) &
                    ({4'h0, slot} < N);
  assign hit_line = is_word(paddr) & (idx == `HSIE_IDX_LINE);
  assign hit_any = hit_en | hit_stat | hit_line;
  assign setup_ph = psel & ~penable;
  // No wait states: every access phase completes on its first edge
  assign pready = 1'b1;
  assign wr_take = psel & penable & pready & pwrite & ~pslverr;
  assign lane0 = pstrb[0];

  // Per-slot registers
  reg [7:0] en_ff [0:N-1];
  reg [7:0] stat_ff [0:N-1];
  wire [N-1:0] slot_pending;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_slot
      wire [7:0] evt;
      wire wr_en_here;
      wire wr_stat_here;
      wire [7:0] clr;
      wire [7:0] nxt_en;
      wire [7:0] nxt_stat;

      assign evt[`HSIE_BIT_CARD_PRESENT_A] = card_a_chg[g];
      assign evt[`HSIE_BIT_CARD_PRESENT_B] = card_b_chg[g];
      assign evt[`HSIE_BIT_MECH_SENSE_A] = mech_a_chg[g];
      assign evt[`HSIE_BIT_MECH_SENSE_B] = mech_b_chg[g];
      assign evt[`HSIE_BIT_POWER_FAULT] = fault_asserted[g];
      assign evt[`HSIE_BIT_POWER_OK] = pwr_ok_chg[g];
      assign evt[`HSIE_BIT_BUS_SWITCH] = bus_sw_low[g];
      assign evt[`HSIE_BIT_RESERVED] = 1'b0;

      assign wr_en_here = wr_take & lane0 & hit_en & (slot == g);
      assign wr_stat_here = wr_take & lane0 & hit_stat & (slot == g);

      // Reserved bit never stores, so it always reads back zero
      assign nxt_en = wr_en_here ? (pwdata[7:0] & `HSIE_WMASK) :
                      en_ff[g];
      // Write one clears; an event in the same cycle wins over the clear
      assign clr = wr_stat_here ? (pwdata[7:0] & `HSIE_WMASK) : 8'h00;
      assign nxt_stat = ((stat_ff[g] & ~clr) | evt) &
                        `HSIE_WMASK;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          en_ff[g] <= `HSIE_EN_RST;
          stat_ff[g] <= `HSIE_STAT_RST;
        end else begin
          en_ff[g] <= nxt_en;
          stat_ff[g] <= nxt_stat;
        end
      end

      // Each enable bit gates its own latched event onto the line
      assign slot_pending[g] = |(stat_ff[g] & en_ff[g]);
    end
  endgenerate

  // Interrupt line
  reg irq_drive_ff;
  wire nxt_irq_drive;

  assign nxt_irq_drive = |slot_pending;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_drive_ff <= 1'b0;
    end else begin
      irq_drive_ff <= nxt_irq_drive;
    end
  end

  // Only ever drives low; other devices may share the wire
  assign hotplug_irq_out = 1'b0;
  assign hotplug_irq_oe = irq_drive_ff;

  // Read path, captured in the setup cycle so the data is a flop output
  reg [31:0] nxt_prdata;
  reg nxt_pslverr;

  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (hit_en) begin
      nxt_prdata[7:0] = en_ff[slot] & `HSIE_WMASK;
    end else if (hit_stat) begin
      nxt_prdata[7:0] = stat_ff[slot] & `HSIE_WMASK;
    end else if (hit_line) begin
      nxt_prdata[`HSIE_BIT_LINE_LOW] = line_low & pins_primed;
      nxt_prdata[`HSIE_BIT_LINE_DRIVE] = irq_drive_ff;
    end else begin
      nxt_pslverr = 1'b1;
    end
    // The line state register is read-only; a write to it is refused
    if (hit_line & pwrite) begin
      nxt_pslverr = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr <= nxt_pslverr;
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: include/hsie_defines.vh
// Register map, field positions, reset values and timing counts for the
// hot-plug slot event interrupt block.
// Assumes a 32-bit APB with byte addresses equal to four times the index.
`ifndef HSIE_DEFINES_VH
`define HSIE_DEFINES_VH

// Register indices; byte address is index times four
`define HSIE_IDX_STAT0 6'h06
`define HSIE_IDX_EN0 6'h07
`define HSIE_IDX_STAT1 6'h0e
`define HSIE_IDX_EN1 6'h0f
`define HSIE_IDX_STAT2 6'h16
`define HSIE_IDX_EN2 6'h17
`define HSIE_IDX_STAT3 6'h1e
`define HSIE_IDX_EN3 6'h1f
`define HSIE_IDX_LINE 6'h20
`define HSIE_IDX_STRIDE 6'h08
`define HSIE_IDX_SLOT_MASK 6'h07
`define HSIE_IDX_LAST_SLOT 6'h1f

// Field positions, shared by enable and status registers
`define HSIE_BIT_CARD_PRESENT_A 0
`define HSIE_BIT_CARD_PRESENT_B 1
`define HSIE_BIT_MECH_SENSE_A 2
`define HSIE_BIT_MECH_SENSE_B 3
`define HSIE_BIT_POWER_FAULT 4
`define HSIE_BIT_POWER_OK 5
`define HSIE_BIT_BUS_SWITCH 6
`define HSIE_BIT_RESERVED 7

// Line state register fields
`define HSIE_BIT_LINE_LOW 0
`define HSIE_BIT_LINE_DRIVE 1

// Reset values and writable masks
`define HSIE_EN_RST 8'h00
`define HSIE_STAT_RST 8'h00
`define HSIE_WMASK 8'h7f

// Edges after reset before a synchronised pin level is trusted
`define HSIE_SYNC_FILL 2'h3

`endif

// file: hdl/hsie_sync3.v
// Three-stage synchroniser with change detection for a vector of pins.
// Assumes asynchronous pin inputs; outputs are in the pclk domain.
`timescale 1ns/10ps
`default_nettype none
`include "hsie_defines.vh"

module hsie_sync3 #(
  parameter WIDTH = 25
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] pin_async,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall,
  output wire primed
);

  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  reg [WIDTH-1:0] lvl_ff;
  reg [WIDTH-1:0] rise_ff;
  reg [WIDTH-1:0] fall_ff;
  reg [1:0] fill_ff;
  reg primed_ff;
  wire filled;
  wire [WIDTH-1:0] agree;
  wire [WIDTH-1:0] nxt_lvl;

  assign filled = (fill_ff == `HSIE_SYNC_FILL);
  // A level counts only once stages two and three agree
  assign agree = ~(s2_ff ^ s3_ff);
  assign nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
      lvl_ff <= {WIDTH{1'b0}};
      rise_ff <= {WIDTH{1'b0}};
      fall_ff <= {WIDTH{1'b0}};
      fill_ff <= 2'h0;
      primed_ff <= 1'b0;
    end else begin
      s1_ff <= pin_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      if (!filled) begin
        fill_ff <= fill_ff + 2'h1;
      end
      // Lags the fill by one edge: the first trusted level after reset
      // lands on that edge and must load without an event
      primed_ff <= filled;
      rise_ff <= primed_ff ? (nxt_lvl & ~lvl_ff) : {WIDTH{1'b0}};
      fall_ff <= primed_ff ? (~nxt_lvl & lvl_ff) : {WIDTH{1'b0}};
    end
  end

  assign level = lvl_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;
  assign primed = primed_ff;

endmodule
`default_nettype wire

// file: dv/hsie_irq_ctrl_chk.sv
// Port assertions for the hot-plug slot interrupt block.
// Bound to hsie_irq_ctrl; mirrors enable writes to judge the interrupt.
`timescale 1ns/10ps
`default_nettype none
module hsie_irq_ctrl_chk #(
  parameter NUM_SLOTS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_SLOTS-1:0] bus_connect_switch_out,
  input wire logic [NUM_SLOTS-1:0] slot_power_ok_in,
  input wire logic [NUM_SLOTS-1:0] slot_power_fault_in,
  input wire logic [NUM_SLOTS-1:0] mech_sense_a_in,
  input wire logic [NUM_SLOTS-1:0] mech_sense_b_in,
  input wire logic [NUM_SLOTS-1:0] card_present_a_in,
  input wire logic [NUM_SLOTS-1:0] card_present_b_in,
  input wire logic hotplug_irq_in,
  input wire logic hotplug_irq_out,
  input wire logic hotplug_irq_oe
);
  logic [3:0][7:0] en_ff;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic en_hit = !paddr[7] && paddr[4:0] == 5'h1c;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      en_ff <= 32'h0;
    else if (wr_acc && pstrb[0] && en_hit)
      en_ff[paddr[6:5]] <= pwdata[7:0] & 8'h7f;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence bus_drop_s;
    $fell(bus_connect_switch_out[2]) && en_ff[2][6];
  endsequence
  sequence fault_on_s;
    $rose(slot_power_fault_in[0]) && en_ff[0][4];
  endsequence
  ready_const_a: assert property (pready)
    else $error("pready low");
  od_data_a: assert property (!hotplug_irq_out)
    else $error("open drain data not low");
  reserved_bit_read_a: assert property (psel && penable && !pwrite |->
    prdata[31:7] == 25'h0) else $error("reserved read bits set");
  en_read_a: assert property (psel && penable && !pwrite &&
    en_hit |-> prdata[7:0] == en_ff[paddr[6:5]])
    else $error("enable readback wrong");
  bus_irq_a: assert property (bus_drop_s |-> ##2 hotplug_irq_oe)
    else $error("no interrupt after bus switch fall");
  fault_irq_a: assert property (fault_on_s |->
    ##[4:6] hotplug_irq_oe) else $error("no interrupt after power fault");
  oe_rise_a: assert property ($rose(hotplug_irq_oe) |-> |en_ff)
    else $error("interrupt with no enable");
  oe_fall_a: assert property ($fell(hotplug_irq_oe) |->
    $past(wr_acc, 2)) else $error("interrupt dropped without a write");
endmodule
bind hsie_irq_ctrl hsie_irq_ctrl_chk #(.NUM_SLOTS(NUM_SLOTS)) hsie_irq_ctrl_chk_i (.*);
`default_nettype wire

// file: dv/hsie_slot_model.sv
// Slot-side pins and the pulled-up shared interrupt wire.
// Assumes the bench asks for pin changes through the flip task.
`timescale 1ns/10ps
`default_nettype none
module hsie_slot_model (
  input wire logic pclk,
  input wire logic irq_oe,
  input wire logic irq_drv,
  output logic irq_wire,
  output logic [23:0] pins
);
  // Pull-up: a released wire reads high, never the last driven value
  assign irq_wire = irq_oe ? irq_drv : 1'b1;
  initial pins = 24'h0;
  // Field f of slot s is bit 4*f+s; changes land just after an edge
  task automatic flip(input int b);
    @(posedge pclk);
    pins[b] <= ~pins[b];
  endtask
endmodule
`default_nettype wire

// file: dv/tb_hotplug_slot_event_irq_enable.sv
// Self-checking bench for the hot-plug slot interrupt block.
// Assumes the slot model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module tb_hotplug_slot_event_irq_enable;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic irq_wire, irq_drv, oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, bcs;
  logic [23:0] pins;
  int miscompares, n_checks;
  hsie_irq_ctrl hsie_irq_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_connect_switch_out(bcs),
    .card_present_a_in(pins[3:0]), .card_present_b_in(pins[7:4]),
    .mech_sense_a_in(pins[11:8]), .mech_sense_b_in(pins[15:12]),
    .slot_power_fault_in(pins[19:16]), .slot_power_ok_in(pins[23:20]),
    .hotplug_irq_in(irq_wire), .hotplug_irq_out(irq_drv),
    .hotplug_irq_oe(oe));
  hsie_slot_model hsie_slot_model_i (.pclk(pclk), .irq_oe(oe),
    .irq_drv(irq_drv), .irq_wire(irq_wire), .pins(pins));
  always #5 pclk = ~pclk;
  task automatic conclude;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  // Byte address of slot s: status when st is 1, enable otherwise
  function automatic logic [7:0] ra(input int s, input int st);
    return 8'(32 * s + (st != 0 ? 24 : 28));
  endfunction
  task automatic t_reset_map;
    logic [31:0] r;
    logic e;
    for (int s = 0; s < 4; s++) begin
      rd(ra(s, 0), 32'h0, 1'b0);
      rd(ra(s, 1), 32'h0, 1'b0);
      wr(ra(s, 0), 32'hff);
      rd(ra(s, 0), 32'h7f, 1'b0);
      wr(ra(s, 0), 32'h0);
    end
    rd(8'h04, 32'h0, 1'b1);
    rd(8'h80, 32'h0, 1'b0);
    apb(1'b1, 8'h80, 32'h0, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
    pstrb <= 4'he;
    wr(ra(0, 0), 32'h7f);
    pstrb <= 4'hf;
    rd(ra(0, 0), 32'h0, 1'b0);
  endtask
  // Power fault is enabled ahead of its event; the others only afterwards
  task automatic t_event(input int f);
    int s;
    logic [31:0] m;
    s = f % 4;
    m = 32'h1 << f;
    if (f == 4)
      wr(ra(s, 0), m);
    hsie_slot_model_i.flip(4 * f + s);
    repeat (8) @(posedge pclk);
    rd(ra(s, 1), m, 1'b0);
    chk("irq_wire", {31'h0, f != 4}, {31'h0, irq_wire});
    wr(ra(s, 0), m);
    repeat (3) @(posedge pclk);
    chk("irq_wire", 32'h0, {31'h0, irq_wire});
    wr(ra(s, 1), 32'h0);
    rd(ra(s, 1), m, 1'b0);
    rd(8'h80, 32'h3, 1'b0);
    wr(ra(s, 1), m);
    wr(ra(s, 0), 32'h0);
    repeat (3) @(posedge pclk);
    chk("irq_wire", 32'h1, {31'h0, irq_wire});
    // Back to the old level: a change counts, a released fault does not
    hsie_slot_model_i.flip(4 * f + s);
    repeat (8) @(posedge pclk);
    rd(ra(s, 1), f == 4 ? 32'h0 : m, 1'b0);
    wr(ra(s, 1), m);
  endtask
  task automatic t_bus;
    wr(ra(2, 0), 32'h40);
    bcs[2] <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("irq_wire", 32'h1, {31'h0, irq_wire});
    bcs[2] <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("irq_wire", 32'h0, {31'h0, irq_wire});
    rd(ra(2, 1), 32'h40, 1'b0);
    wr(ra(2, 1), 32'h40);
    wr(ra(2, 0), 32'h0);
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    bcs = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset_map();
    for (int f = 0; f < 6; f++)
      t_event(f);
    t_bus();
    conclude();
  end
endmodule
`default_nettype wire
